// file: rtl/sbsf_defs.vh
// Constants for the serial bus status flag block
`ifndef SBSF_DEFS_VH
`define SBSF_DEFS_VH
// Register indexes; byte address is four times the index
`define SBSF_IDX_STATUS   16'hff79
`define SBSF_IDX_CONTROL  16'hff78
`define SBSF_IDX_SLAVE    16'hff7a
`define SBSF_ADDR_W       18
// Status bit positions
`define SBSF_BIT_MASTER   7
`define SBSF_BIT_ARB      6
`define SBSF_BIT_EXT      5
`define SBSF_BIT_MATCH    4
// Control bit positions
`define SBSF_BIT_ENABLE   7
`define SBSF_BIT_RELEASE  6
// Reset values
`define SBSF_RST_STATUS   8'h00
`define SBSF_RST_CONTROL  8'h00
`define SBSF_RST_SLAVE    8'h00
// Address byte bit count and extension-code upper nibble values
`define SBSF_ADDR_BITS    4'h8
`define SBSF_EXT_LOW      4'h0
`define SBSF_EXT_HIGH     4'hf
`endif

// file: rtl/sbsf_status_flags.v
// Upper status flags of the two-wire serial bus interface
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sbsf_defs.vh"

// Summary of operation
// - Eight-bit read-only status: four flags high, four outer flags low; high four reset zero.
// - Master-active reads one while acting as bus master, whether transmitting or receiving.
// - Master-active sets while this interface generates a start condition.
// - Stop detected clears master-active, extension-code and address-match.
// - Lost arbitration sets arbitration-lost and clears master-active together.
// - Arbitration-lost clears automatically after the status register is read.
// - A bit manipulation on another status bit also clears arbitration-lost.
// - Extension-code sets at 8th address clock when upper nibble is 0000/1111.
// - Address-match sets at 8th address clock when address equals own address.
// - Start detected clears extension-code and address-match.
// - Enable falling clears all four; release clears all but arbitration-lost.
module sbsf_status_flags (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [`SBSF_ADDR_W-1:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Two-wire bus pins, sampled only
  input  wire        scl_in,
  input  wire        sda_in,
  // Bus-event strobes from shift and wait logic
  input  wire        start_gen_pulse,
  input  wire        arb_lost_pulse,
  input  wire        transmit_dir_flag,
  input  wire        ack_seen_flag,
  input  wire        start_seen_flag,
  input  wire        stop_seen_flag,
  // Flag and control outputs
  output reg         master_active_flag,
  output reg         arb_lost_flag,
  output reg         ext_code_flag,
  output reg         addr_match_flag,
  output reg         bus_if_enable_bit
);

  localparam [`SBSF_ADDR_W-1:0] ADR_STATUS  = {`SBSF_IDX_STATUS, 2'b00};
  localparam [`SBSF_ADDR_W-1:0] ADR_CONTROL = {`SBSF_IDX_CONTROL, 2'b00};
  localparam [`SBSF_ADDR_W-1:0] ADR_SLAVE   = {`SBSF_IDX_SLAVE, 2'b00};

  // Pin synchronisers
  wire       scl_s2_ff;
  wire       scl_old_ff;
  wire       sda_s2_ff;
  wire       sda_old_ff;
  localparam [7:0] RST_STATUS = `SBSF_RST_STATUS;
  // Address byte tracking
  reg  [3:0] bit_cnt_ff;
  reg        in_addr_ff;
  reg  [6:0] shift_ff;
  // Software state
  reg  [7:0] own_slave_addr_reg;
  reg        en_old_ff;

  wire scl_rise  = scl_s2_ff & ~scl_old_ff;
  wire start_det = scl_s2_ff & scl_old_ff & sda_old_ff & ~sda_s2_ff;
  wire stop_det  = scl_s2_ff & scl_old_ff & ~sda_old_ff & sda_s2_ff;
  wire eighth    = bus_if_enable_bit & in_addr_ff & scl_rise &
                   (bit_cnt_ff == `SBSF_ADDR_BITS - 4'h1);
  wire [7:0] rx_addr = {shift_ff, sda_s2_ff};

  wire [7:0] serial_bus_status_reg = {master_active_flag, arb_lost_flag,
                                      ext_code_flag, addr_match_flag,
                                      transmit_dir_flag, ack_seen_flag,
                                      start_seen_flag, stop_seen_flag};

  // Bus handshake: request seen, answered next cycle
  wire req      = avs_read | avs_write;
  wire done     = req & ~avs_waitrequest;
  wire rd_done  = avs_read & ~avs_waitrequest;
  wire wr_done  = avs_write & ~avs_waitrequest;
  wire wr_ctl   = wr_done & (avs_address == ADR_CONTROL);
  wire release_hit = wr_ctl & avs_writedata[`SBSF_BIT_RELEASE];
  wire enable_fall = en_old_ff & ~bus_if_enable_bit;
  // Read clears only what it actually returned
  wire rd_status = rd_done & (avs_address == ADR_STATUS) &
                   avs_readdata[`SBSF_BIT_ARB];
  wire bitop_status = wr_done & (avs_address == ADR_STATUS);

  reg [31:0] nxt_readdata;

  always @* begin
    nxt_readdata = 32'h0000_0000;
    if (avs_address == ADR_STATUS) begin
      nxt_readdata[7:0] = serial_bus_status_reg;
    end else if (avs_address == ADR_CONTROL) begin
      nxt_readdata[`SBSF_BIT_ENABLE] = bus_if_enable_bit;
    end else if (avs_address == ADR_SLAVE) begin
      nxt_readdata[7:0] = own_slave_addr_reg;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest    <= 1'b1;
      avs_readdata       <= 32'h0000_0000;
      bus_if_enable_bit  <= 1'b0;
      en_old_ff          <= 1'b0;
      own_slave_addr_reg <= `SBSF_RST_SLAVE;
    end else begin
      en_old_ff <= bus_if_enable_bit;
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        // Snapshot before any clear
        avs_readdata    <= nxt_readdata;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_ctl)
        bus_if_enable_bit <= avs_writedata[`SBSF_BIT_ENABLE];
      if (wr_done & (avs_address == ADR_SLAVE))
        own_slave_addr_reg <= avs_writedata[7:0];
    end
  end

  // Two flops before any logic reads the pins
  sbsf_pin_sync #(
    .IDLE (1'b1)
  ) i_scl_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (scl_in),
    .level_ff (scl_s2_ff),
    .prev_ff  (scl_old_ff)
  );

  sbsf_pin_sync #(
    .IDLE (1'b1)
  ) i_sda_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (sda_in),
    .level_ff (sda_s2_ff),
    .prev_ff  (sda_old_ff)
  );

  // Only the byte right after a start is an address byte
  always @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_ff <= 4'h0;
      in_addr_ff <= 1'b0;
      shift_ff   <= 7'h00;
    end else if (start_det | stop_det | ~bus_if_enable_bit) begin
      bit_cnt_ff <= 4'h0;
      in_addr_ff <= start_det & bus_if_enable_bit;
      shift_ff   <= 7'h00;
    end else if (in_addr_ff & scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff   <= rx_addr[6:0];
      if (eighth)
        in_addr_ff <= 1'b0;
    end
  end

  // Master-active: disable beats all, then a defeat, then a set wins over a clear
  always @(posedge clk) begin
    if (sys_rst) begin
      master_active_flag <= RST_STATUS[`SBSF_BIT_MASTER];
    end else if (enable_fall) begin
      master_active_flag <= 1'b0;
    end else if (arb_lost_pulse) begin
      master_active_flag <= 1'b0;
    end else if (start_gen_pulse & bus_if_enable_bit) begin
      master_active_flag <= 1'b1;
    end else if (stop_det | release_hit) begin
      master_active_flag <= 1'b0;
    end
  end

  // Arbitration-lost: release leaves it alone
  always @(posedge clk) begin
    if (sys_rst) begin
      arb_lost_flag <= RST_STATUS[`SBSF_BIT_ARB];
    end else if (enable_fall) begin
      arb_lost_flag <= 1'b0;
    end else if (arb_lost_pulse & bus_if_enable_bit) begin
      arb_lost_flag <= 1'b1;
    end else if (rd_status | bitop_status) begin
      arb_lost_flag <= 1'b0;
    end
  end

  // Extension-code
  always @(posedge clk) begin
    if (sys_rst) begin
      ext_code_flag <= RST_STATUS[`SBSF_BIT_EXT];
    end else if (enable_fall) begin
      ext_code_flag <= 1'b0;
    end else if (eighth & ((rx_addr[7:4] == `SBSF_EXT_LOW) |
                           (rx_addr[7:4] == `SBSF_EXT_HIGH))) begin
      ext_code_flag <= 1'b1;
    end else if (start_det | stop_det | release_hit) begin
      ext_code_flag <= 1'b0;
    end
  end

  // Address-match; direction bit is not part of the match
  always @(posedge clk) begin
    if (sys_rst) begin
      addr_match_flag <= RST_STATUS[`SBSF_BIT_MATCH];
    end else if (enable_fall) begin
      addr_match_flag <= 1'b0;
    end else if (eighth & (rx_addr[7:1] == own_slave_addr_reg[7:1])) begin
      addr_match_flag <= 1'b1;
    end else if (start_det | stop_det | release_hit) begin
      addr_match_flag <= 1'b0;
    end
  end

endmodule

// Two-flop synchroniser plus one history flop for edge finding
module sbsf_pin_sync #(
  // Idle level of the pin, so no false edge follows reset
  parameter [0:0] IDLE = 1'b1
) (
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  // Pin and synchronised view
  input  wire pin_in,
  output reg  level_ff,
  output reg  prev_ff
);

  reg meta_ff;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_ff  <= IDLE;
      level_ff <= IDLE;
      prev_ff  <= IDLE;
    end else begin
      meta_ff  <= pin_in;
      level_ff <= meta_ff;
      prev_ff  <= level_ff;
    end
  end

endmodule
`default_nettype wire

// file: bench/sbsf_bus_peer.sv
// Model of another master on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module sbsf_bus_peer (
  // Bus lines, pulled high when idle
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, address byte, acked 9th clock; clock stands high between frames
  task automatic frame(logic [7:0] a);
    #62.5 sda = 1'b0;
    for (int i = 7; i >= -1; i--) begin
      #62.5 scl = 1'b0;
      sda = i < 0 ? 1'b0 : a[i];
      #62.5 scl = 1'b1;
    end
  endtask
  // Hold after stop so the flags can settle
  task automatic stop;
    #62.5 sda = 1'b1;
    #62.5;
  endtask
endmodule
`default_nettype wire

// file: bench/sbsf_status_flags_properties.sv
// Checker for the upper status flags
`timescale 1ns/1ps
`default_nettype none
module sbsf_status_flags_properties (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and strobes
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        start_gen_pulse,
  input wire logic        arb_lost_pulse,
  // Flags
  input wire logic        master_active_flag,
  input wire logic        arb_lost_flag,
  input wire logic        ext_code_flag,
  input wire logic        addr_match_flag,
  input wire logic        bus_if_enable_bit
);
  wire logic [3:0] hi = {master_active_flag, arb_lost_flag, ext_code_flag,
    addr_match_flag};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence start_s; scl_in && $fell(sda_in); endsequence
  sequence stop_s; scl_in && $rose(sda_in); endsequence
  sequence rd_s; avs_read && !avs_waitrequest && avs_address == 18'h3fde4;
  endsequence
  ack_once_a: assert property (avs_read && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("ack");
  rd_data_a: assert property (rd_s |->
    avs_readdata[31:4] == {24'h0, $past(hi)}) else $error("read data");
  rd_clr_a: assert property (
    rd_s ##0 avs_readdata[6] && !arb_lost_pulse |=> !arb_lost_flag)
    else $error("read clear");
  arb_set_a: assert property (arb_lost_pulse && bus_if_enable_bit
    |=> arb_lost_flag && !master_active_flag) else $error("arb set");
  start_set_a: assert property (
    start_gen_pulse && !arb_lost_pulse && bus_if_enable_bit
    |=> master_active_flag) else $error("start set");
  stop_clr_a: assert property (stop_s |-> ##5
    !(master_active_flag || ext_code_flag || addr_match_flag))
    else $error("stop clear");
  start_clr_a: assert property (start_s |-> ##5
    !(ext_code_flag || addr_match_flag)) else $error("start clear");
  en_fall_a: assert property ($fell(bus_if_enable_bit)
    |=> hi == 4'h0) else $error("disable clear");
endmodule
bind sbsf_status_flags sbsf_status_flags_properties i_chk (
  .clk                (clk),
  .sys_rst            (sys_rst),
  .avs_address        (avs_address),
  .avs_read           (avs_read),
  .avs_readdata       (avs_readdata),
  .avs_waitrequest    (avs_waitrequest),
  .scl_in             (scl_in),
  .sda_in             (sda_in),
  .start_gen_pulse    (start_gen_pulse),
  .arb_lost_pulse     (arb_lost_pulse),
  .master_active_flag (master_active_flag),
  .arb_lost_flag      (arb_lost_flag),
  .ext_code_flag      (ext_code_flag),
  .addr_match_flag    (addr_match_flag),
  .bus_if_enable_bit  (bus_if_enable_bit)
);
`default_nettype wire

// file: bench/sbsf_status_flags_tb.sv
// Bench for the upper status flags
`timescale 1ns/1ps
`default_nettype none
module sbsf_status_flags_tb;
  localparam logic [17:0] st = 18'h3fde4, ct = 18'h3fde0;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic        scl_in, sda_in, start_gen_pulse, arb_lost_pulse;
  logic        transmit_dir_flag, ack_seen_flag, start_seen_flag;
  logic        stop_seen_flag, master_active_flag, arb_lost_flag;
  logic        ext_code_flag, addr_match_flag, bus_if_enable_bit;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q[$];
  logic [7:0]  sa, a;
  logic [3:0]  lv;
  int          checks, mismatches;
  assign {transmit_dir_flag, ack_seen_flag, start_seen_flag,
    stop_seen_flag} = lv;
  sbsf_bus_peer i_peer (.scl(scl_in), .sda(sda_in));
  sbsf_status_flags i_dut (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .scl_in             (scl_in),
    .sda_in             (sda_in),
    .start_gen_pulse    (start_gen_pulse),
    .arb_lost_pulse     (arb_lost_pulse),
    .transmit_dir_flag  (transmit_dir_flag),
    .ack_seen_flag      (ack_seen_flag),
    .start_seen_flag    (start_seen_flag),
    .stop_seen_flag     (stop_seen_flag),
    .master_active_flag (master_active_flag),
    .arb_lost_flag      (arb_lost_flag),
    .ext_code_flag      (ext_code_flag),
    .addr_match_flag    (addr_match_flag),
    .bus_if_enable_bit  (bus_if_enable_bit)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD readdata exp %h seen %h", e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(logic w, logic [17:0] ad, logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n == 40) begin
      mismatches++;
      finish_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(logic [17:0] ad, logic [7:0] e);
    q.push_back({24'h0, e});
    bus(1'b0, ad, 8'h00);
  endtask
  task automatic pulse(logic g);
    @(posedge clk);
    start_gen_pulse <= g;
    arb_lost_pulse <= !g;
    @(posedge clk);
    start_gen_pulse <= 1'b0;
    arb_lost_pulse <= 1'b0;
  endtask
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, q.pop_front());
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, start_gen_pulse, arb_lost_pulse} = 4'h0;
    avs_address = 18'h0;
    avs_writedata = 32'h0;
    void'($urandom(32'h21e5));
    lv = 4'($urandom);
    sa = 8'h10 + 8'($urandom_range(8'hdf));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(st, {4'h0, lv});
    rd(18'h00100, 8'h00);
    bus(1'b1, ct, 8'h80);
    bus(1'b1, 18'h3fde8, sa);
    rd(ct, 8'h80);
    rd(18'h3fde8, sa);
    $display("test 1 done");
    for (int k = 0; k < 4; k++) begin
      a = k == 0 ? {4'h0, 4'($urandom)} : k == 1 ? {4'hf, 4'($urandom)}
        : sa ^ (8'h01 << (k - 2));
      i_peer.frame(a);
      rd(st, {2'b00, a[7:4] == 4'h0 || a[7:4] == 4'hf,
        a[7:1] == sa[7:1], lv});
      i_peer.stop();
      rd(st, {4'h0, lv});
    end
    $display("test 2 done");
    pulse(1'b1);
    rd(st, {4'h8, lv});
    pulse(1'b0);
    rd(st, {4'h4, lv});
    rd(st, {4'h0, lv});
    pulse(1'b0);
    bus(1'b1, st, 8'h01);
    rd(st, {4'h0, lv});
    i_peer.frame(8'h00);
    pulse(1'b0);
    pulse(1'b1);
    bus(1'b1, ct, 8'hc0);
    rd(st, {4'h4, lv});
    pulse(1'b0);
    pulse(1'b1);
    bus(1'b1, ct, 8'h00);
    rd(st, {4'h0, lv});
    i_peer.stop();
    $display("test 3 done");
    finish_test();
  end
endmodule
`default_nettype wire
